// *** tsr_block_mem.sv ***
// Registered-read block store that holds the tag's data blocks and its system block.
`timescale 1ns/1ps
`default_nettype none

module tsr_block_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 17,
	parameter int AW    = 5
) (
	input  wire logic             clock_in,
	input  wire logic             arst_n_in,
	input  wire logic             wr_en_in,
	input  wire logic [AW-1:0]    wr_addr_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic             rd_en_in,
	input  wire logic [AW-1:0]    rd_addr_in,
	output logic      [WIDTH-1:0] rd_data_out
);

	// The array itself has no reset, so it maps onto plain storage cells.
	logic [WIDTH-1:0] store_q [DEPTH];

	always_ff @(posedge clock_in) begin
		if (wr_en_in) begin
			store_q[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_data_out <= '0;
		end else if (rd_en_in) begin
			rd_data_out <= store_q[rd_addr_in];
		end
	end

endmodule

`default_nettype wire

// *** tsr_tag_cmd.sv ***
// Constants and command interpreter of the contactless tag, with its answer buffer.
`timescale 1ns/1ps
`default_nettype none

package tsr_pkg;
	localparam logic [3:0]  SLOT_CODE      = 4'h6;
	localparam logic [3:0]  SLOT_NONE      = 4'h0;
	localparam logic [7:0]  OP_INV         = 8'h06;
	localparam logic [7:0]  SUB_OPEN       = 8'h00;
	localparam logic [7:0]  SUB_POLL       = 8'h04;
	localparam logic [7:0]  OP_SELECT      = 8'h0E;
	localparam logic [7:0]  OP_FINISH      = 8'h0F;
	localparam logic [7:0]  OP_BACK        = 8'h0C;
	localparam logic [7:0]  OP_FETCH       = 8'h08;
	localparam logic [7:0]  LAST_DATA_ADDR = 8'h0F;
	localparam logic [7:0]  SYS_ADDR       = 8'hFF;
	localparam logic [4:0]  SYS_INDEX      = 5'h10;
	localparam logic [2:0]  LAST_IDX_SHORT = 3'h2;
	localparam logic [2:0]  LAST_IDX_LONG  = 3'h3;
	localparam logic [2:0]  CNT_MAX        = 3'h7;
	localparam logic [1:0]  LEN_LABEL      = 2'h0;
	localparam logic [1:0]  LEN_BLOCK      = 2'h3;
	localparam logic [15:0] CRC_INIT       = 16'hFFFF;
	localparam logic [15:0] CRC_POLY       = 16'h8408;
	localparam logic [7:0]  RAND_SEED      = 8'hA5;
	localparam logic [7:0]  RAND_TAPS      = 8'h1D;
	localparam int          TURN_GAP_CYC   = 8;

	typedef enum logic [2:0] {
		TAG_READY       = 3'b000,
		TAG_INVENTORY   = 3'b001,
		TAG_SELECTED    = 3'b010,
		TAG_DESELECTED  = 3'b011,
		TAG_DEACTIVATED = 3'b100
	} tsr_tag_e;

	typedef enum logic [2:0] {
		TX_IDLE   = 3'b000,
		TX_GAP    = 3'b001,
		TX_DATA   = 3'b010,
		TX_CHK_LO = 3'b011,
		TX_CHK_HI = 3'b100
	} tsr_tx_e;

	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} tsr_req_s;

	typedef struct packed {
		logic [7:0] data;
		logic       first;
		logic       last;
	} tsr_ans_s;

	// Reflected CRC, each byte taken least significant bit first.
	function automatic logic [15:0] tsr_crc_step(input logic [15:0] crc, input logic [7:0] d);
		logic [15:0] c;
		c = crc;
		for (int i = 0; i < 8; i++) begin
			if (c[0] ^ d[i]) begin
				c = (c >> 1) ^ CRC_POLY;
			end else begin
				c = c >> 1;
			end
		end
		return c;
	endfunction
endpackage

module tsr_tag_cmd #(
	parameter int GAP_CYC = tsr_pkg::TURN_GAP_CYC
) (
	input  wire logic             clock_in,
	input  wire logic             arst_n_in,
	input  wire logic             req_valid_in,
	input  wire tsr_pkg::tsr_req_s req_in,
	input  wire logic             load_en_in,
	input  wire logic [4:0]       load_addr_in,
	input  wire logic [31:0]      load_data_in,
	input  wire logic             ans_ready_in,
	output logic                  ans_valid_out,
	output tsr_pkg::tsr_ans_s     ans_out,
	output tsr_pkg::tsr_tag_e     tag_state_out
);

	tsr_pkg::tsr_tag_e state_q;
	tsr_pkg::tsr_tag_e state_d;
	tsr_pkg::tsr_tx_e  tx_q;
	logic [2:0]        cnt_q;
	logic [7:0]        op_q;
	logic [7:0]        arg_q;
	logic [7:0]        d1_q;
	logic [7:0]        d2_q;
	logic [15:0]       rx_crc_q;
	logic [7:0]        rand_q;
	logic [7:0]        label_q;
	logic [7:0]        label_d;
	logic [31:0]       pay_q;
	logic [1:0]        plen_q;
	logic [1:0]        bidx_q;
	logic              fetch_q;
	logic [15:0]       tx_crc_q;
	logic [7:0]        gap_q;
	logic [31:0]       mem_rdata;
	tsr_pkg::tsr_ans_s e1_q;
	logic              v1_q;

	// Requests that arrive while an answer is under way are dropped: the link is half duplex.
	wire busy       = (tx_q != tsr_pkg::TX_IDLE);
	wire take       = req_valid_in && !busy;
	wire frame_done = take && req_in.last;
	wire [15:0] crc_now = tsr_pkg::tsr_crc_step(rx_crc_q, d2_q);
	wire crc_good = (cnt_q >= tsr_pkg::LAST_IDX_SHORT) && (~crc_now == {req_in.data, d1_q});
	wire is_short = (cnt_q == tsr_pkg::LAST_IDX_SHORT);
	wire is_long  = (cnt_q == tsr_pkg::LAST_IDX_LONG);
	wire is_open  = is_long && op_q == tsr_pkg::OP_INV && arg_q == tsr_pkg::SUB_OPEN;
	wire is_poll  = is_long && op_q == tsr_pkg::OP_INV && arg_q == tsr_pkg::SUB_POLL;
	wire is_slot  = is_short && op_q[3:0] == tsr_pkg::SLOT_CODE && op_q[7:4] != tsr_pkg::SLOT_NONE;
	wire is_sel   = is_long && op_q == tsr_pkg::OP_SELECT;
	wire is_fin   = is_short && op_q == tsr_pkg::OP_FINISH;
	wire is_back  = is_short && op_q == tsr_pkg::OP_BACK;
	wire is_fetch = is_long && op_q == tsr_pkg::OP_FETCH;
	wire addr_ok  = (arg_q <= tsr_pkg::LAST_DATA_ADDR) || (arg_q == tsr_pkg::SYS_ADDR);
	// A deactivated tag decodes nothing until the field drops and resets it.
	wire accepted = frame_done && crc_good && state_q != tsr_pkg::TAG_DEACTIVATED;
	wire in_ready = (state_q == tsr_pkg::TAG_READY);
	wire in_inv   = (state_q == tsr_pkg::TAG_INVENTORY);
	wire in_sel   = (state_q == tsr_pkg::TAG_SELECTED);
	wire in_desel = (state_q == tsr_pkg::TAG_DESELECTED);
	wire lab_match = (arg_q == label_q);
	wire slot_hit  = (op_q[7:4] == label_q[3:0]);
	wire do_open  = accepted && is_open && in_ready;
	wire do_poll  = accepted && is_poll && in_inv;
	wire do_slot  = accepted && is_slot && in_inv;
	wire do_sel   = accepted && is_sel && (in_inv || in_sel || in_desel);
	wire do_fetch = accepted && is_fetch && in_sel && addr_ok;
	wire ans_go   = do_open || (do_poll && rand_q[3:0] == tsr_pkg::SLOT_NONE) || (do_slot && slot_hit)
	                || (do_sel && lab_match) || do_fetch;
	wire [4:0] rd_addr = (arg_q == tsr_pkg::SYS_ADDR) ? tsr_pkg::SYS_INDEX : arg_q[4:0];

	// Next tag state and label.
	always_comb begin
		state_d = state_q;
		label_d = label_q;
		if (do_open) begin
			state_d = tsr_pkg::TAG_INVENTORY;
			label_d = rand_q;
		end else if (do_poll) begin
			label_d = {label_q[7:4], rand_q[3:0]};
		end else if (do_sel && lab_match) begin
			state_d = tsr_pkg::TAG_SELECTED;
		end else if (do_sel && in_sel) begin
			state_d = tsr_pkg::TAG_DESELECTED;
		end else if (accepted && is_fin && in_sel) begin
			state_d = tsr_pkg::TAG_DEACTIVATED;
		end else if (accepted && is_back && in_sel) begin
			state_d = tsr_pkg::TAG_INVENTORY;
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= tsr_pkg::TAG_READY;
			tag_state_out <= tsr_pkg::TAG_READY;
			label_q <= '0;
			rand_q  <= tsr_pkg::RAND_SEED;
		end else begin
			state_q <= state_d;
			tag_state_out <= state_d;
			label_q <= label_d;
			rand_q  <= {rand_q[6:0], 1'b0} ^ (rand_q[7] ? tsr_pkg::RAND_TAPS : '0);
		end
	end

	// Request capture: the check runs two bytes behind so the trailing check bytes are not folded in.
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_q    <= '0;
			op_q     <= '0;
			arg_q    <= '0;
			d1_q     <= '0;
			d2_q     <= '0;
			rx_crc_q <= tsr_pkg::CRC_INIT;
		end else if (frame_done) begin
			cnt_q    <= '0;
			rx_crc_q <= tsr_pkg::CRC_INIT;
		end else if (take) begin
			cnt_q <= (cnt_q == tsr_pkg::CNT_MAX) ? cnt_q : cnt_q + 3'h1;
			d1_q  <= req_in.data;
			d2_q  <= d1_q;
			op_q     <= (cnt_q == 3'h0) ? req_in.data : op_q;
			arg_q    <= (cnt_q == 3'h1) ? req_in.data : arg_q;
			rx_crc_q <= (cnt_q >= tsr_pkg::LAST_IDX_SHORT) ? crc_now : rx_crc_q;
		end
	end

	tsr_block_mem #(
		.WIDTH (32),
		.DEPTH (17),
		.AW    (5)
	) u_mem (
		.clock_in    (clock_in),
		.arst_n_in   (arst_n_in),
		.wr_en_in    (load_en_in),
		.wr_addr_in  (load_addr_in),
		.wr_data_in  (load_data_in),
		.rd_en_in    (do_fetch),
		.rd_addr_in  (rd_addr),
		.rd_data_out (mem_rdata)
	);

	// Answer producer feeding the two-entry buffer.
	wire buf_ready = !v1_q;
	wire gap_end   = (gap_q == 8'(GAP_CYC - 1));
	wire tx_data   = (tx_q == tsr_pkg::TX_DATA);
	wire push      = buf_ready && (tx_data || tx_q == tsr_pkg::TX_CHK_LO || tx_q == tsr_pkg::TX_CHK_HI);
	wire [7:0] pay_byte = pay_q[{bidx_q, 3'h0} +: 8];
	wire [7:0] push_data = tx_data ? pay_byte
	                     : (tx_q == tsr_pkg::TX_CHK_LO) ? ~tx_crc_q[7:0] : ~tx_crc_q[15:8];
	wire tsr_pkg::tsr_ans_s push_ent = '{data: push_data, first: tx_data && bidx_q == 2'h0,
	                                     last: tx_q == tsr_pkg::TX_CHK_HI};

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tx_q     <= tsr_pkg::TX_IDLE;
			gap_q    <= '0;
			pay_q    <= '0;
			plen_q   <= '0;
			bidx_q   <= '0;
			fetch_q  <= 1'b0;
			tx_crc_q <= tsr_pkg::CRC_INIT;
		end else begin
			case (tx_q)
				tsr_pkg::TX_IDLE: begin
					if (ans_go) begin
						tx_q    <= tsr_pkg::TX_GAP;
						gap_q   <= '0;
						fetch_q <= do_fetch;
						plen_q  <= do_fetch ? tsr_pkg::LEN_BLOCK : tsr_pkg::LEN_LABEL;
						pay_q   <= {24'h0, label_d};
					end
				end
				tsr_pkg::TX_GAP: begin
					gap_q <= gap_q + 8'h1;
					if (gap_end) begin
						tx_q     <= tsr_pkg::TX_DATA;
						bidx_q   <= '0;
						tx_crc_q <= tsr_pkg::CRC_INIT;
						if (fetch_q) begin
							pay_q <= mem_rdata;
						end
					end
				end
				tsr_pkg::TX_DATA: begin
					if (push) begin
						tx_crc_q <= tsr_pkg::tsr_crc_step(tx_crc_q, pay_byte);
						bidx_q   <= bidx_q + 2'h1;
						if (bidx_q == plen_q) begin
							tx_q <= tsr_pkg::TX_CHK_LO;
						end
					end
				end
				tsr_pkg::TX_CHK_LO: begin
					if (push) begin
						tx_q <= tsr_pkg::TX_CHK_HI;
					end
				end
				default: begin
					if (push) begin
						tx_q <= tsr_pkg::TX_IDLE;
					end
				end
			endcase
		end
	end

	// Two-entry buffer: a stall by the receiver backs up into the producer instead of losing bytes.
	wire pop = ans_valid_out && ans_ready_in;
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ans_valid_out <= 1'b0;
			ans_out       <= '0;
			e1_q          <= '0;
			v1_q          <= 1'b0;
		end else if (pop && push) begin
			ans_out <= push_ent;
		end else if (pop) begin
			ans_out       <= e1_q;
			ans_valid_out <= v1_q;
			v1_q          <= 1'b0;
		end else if (push && !ans_valid_out) begin
			ans_out       <= push_ent;
			ans_valid_out <= 1'b1;
		end else if (push) begin
			e1_q <= push_ent;
			v1_q <= 1'b1;
		end
	end

	slot_ignore_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		(frame_done && is_slot && !in_inv && !busy) |=> (tx_q == tsr_pkg::TX_IDLE))
		else $error("Slot query answered outside Inventory.");

	slot_answer_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		(accepted && is_slot && in_inv && slot_hit) |=> (tx_q == tsr_pkg::TX_GAP && pay_q[7:0] == $past(label_q)))
		else $error("Matching slot query did not start a label answer.");

	select_enter_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		(do_sel && lab_match) |=> (state_q == tsr_pkg::TAG_SELECTED && pay_q[7:0] == $past(arg_q)))
		else $error("Matching select did not select or echo the label.");

	select_drop_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		(do_sel && in_sel && !lab_match) |=> (state_q == tsr_pkg::TAG_DESELECTED && tx_q == tsr_pkg::TX_IDLE))
		else $error("Mismatching select did not deselect silently.");

	finish_lock_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		(state_q == tsr_pkg::TAG_DEACTIVATED) |=> (state_q == tsr_pkg::TAG_DEACTIVATED) [*2])
		else $error("Deactivated tag left its locked state.");

	finish_quiet_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		(accepted && is_fin && in_sel) |=> (state_q == tsr_pkg::TAG_DEACTIVATED && tx_q == tsr_pkg::TX_IDLE))
		else $error("Finish did not deactivate silently.");

	back_search_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		(accepted && is_back && in_sel) |=> (state_q == tsr_pkg::TAG_INVENTORY && tx_q == tsr_pkg::TX_IDLE))
		else $error("Back-to-search did not return silently to Inventory.");

	fetch_guard_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		(frame_done && is_fetch && (!in_sel || !addr_ok) && !busy) |=> (tx_q == tsr_pkg::TX_IDLE))
		else $error("Fetch answered outside Selected or with a bad address.");

	bad_check_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		(frame_done && !crc_good) |=> (state_q == $past(state_q) && label_q == $past(label_q) && !busy))
		else $error("Frame with a bad check had an effect.");

	check_tail_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		(push && tx_q == tsr_pkg::TX_CHK_LO) |=> (push && push_ent.last && tx_q == tsr_pkg::TX_CHK_HI)
		or (!push && tx_q == tsr_pkg::TX_CHK_HI))
		else $error("Check high byte did not follow check low byte.");

endmodule

`default_nettype wire

// *** tsr_reader_model.sv ***
// Reader model that frames requests with their check bytes and gathers answer bytes.
`timescale 1ns/1ps
`default_nettype none

module tsr_reader_model (
	input  wire logic              clock_in,
	input  wire logic              stall_in,
	input  wire logic              ans_valid_in,
	input  wire tsr_pkg::tsr_ans_s ans_in,
	output logic                   req_valid_out,
	output var tsr_pkg::tsr_req_s  req_out,
	output logic                   ans_ready_out
);
	tsr_pkg::tsr_ans_s rx[$];

	initial begin
		req_valid_out = 1'b0;
		req_out = '0;
	end

	function automatic logic [15:0] chk(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[k]) begin
			for (int i = 0; i < 8; i++) begin
				c = (c[0] ^ b[k][i]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
			end
		end
		return ~c;
	endfunction

	// A corrupted frame flips one bit of the low check byte only.
	task automatic send(input logic [7:0] b[$], input bit bad);
		logic [15:0] c;
		c = chk(b);
		b.push_back(c[7:0] ^ {7'h00, bad});
		b.push_back(c[15:8]);
		foreach (b[k]) begin
			@(posedge clock_in);
			req_valid_out <= 1'b1;
			req_out <= '{data: b[k], last: (k == b.size() - 1)};
		end
		@(posedge clock_in);
		req_valid_out <= 1'b0;
		// The released line shows the inverse so a stale byte cannot pass for a fresh one.
		req_out <= '{data: ~req_out.data, last: 1'b0};
	endtask

	always @(posedge clock_in) begin
		if (ans_valid_in && ans_ready_out) begin
			rx.push_back(ans_in);
		end
		ans_ready_out <= ~stall_in;
	end
endmodule

`default_nettype wire

// *** tag_select_read_commands_bench.sv ***
// Self-checking bench with a reader model and a reference of the tag's states and store.
`timescale 1ns/1ps
`default_nettype none

module tag_select_read_commands_bench;
	localparam int GAP = 2;
	localparam tsr_pkg::tsr_tag_e RDY = tsr_pkg::TAG_READY;
	localparam tsr_pkg::tsr_tag_e INV = tsr_pkg::TAG_INVENTORY;
	localparam tsr_pkg::tsr_tag_e SEL = tsr_pkg::TAG_SELECTED;
	localparam tsr_pkg::tsr_tag_e DES = tsr_pkg::TAG_DESELECTED;
	localparam tsr_pkg::tsr_tag_e DEA = tsr_pkg::TAG_DEACTIVATED;

	logic              clock_in = 1'b0;
	logic              arst_n_in = 1'b0;
	logic              slow = 1'b0;
	logic              stall = 1'b0;
	logic              load_en = 1'b0;
	logic [4:0]        load_addr = 5'h00;
	logic [31:0]       load_data = 32'h0000_0000;
	logic              req_valid;
	tsr_pkg::tsr_req_s req;
	logic              ans_ready;
	logic              ans_valid;
	tsr_pkg::tsr_ans_s ans;
	tsr_pkg::tsr_tag_e state;
	logic [31:0]       rs = 32'hD82CE2AA;
	logic [31:0]       mem [17];
	logic [7:0]        lbl;
	logic [7:0]        pl[$];
	int                miscompares = 0;
	int                cmp_count = 0;

	always #12.5 clock_in = ~clock_in;

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	always @(posedge clock_in) begin
		rs <= xs(rs);
		stall <= slow & rs[0];
	end

	tsr_tag_cmd #(.GAP_CYC(GAP)) u_tsr_tag_cmd (.clock_in(clock_in), .arst_n_in(arst_n_in),
		.req_valid_in(req_valid), .req_in(req), .load_en_in(load_en), .load_addr_in(load_addr),
		.load_data_in(load_data), .ans_ready_in(ans_ready), .ans_valid_out(ans_valid),
		.ans_out(ans), .tag_state_out(state));

	tsr_reader_model u_tsr_reader_model (.clock_in(clock_in), .stall_in(stall), .ans_valid_in(ans_valid),
		.ans_in(ans), .req_valid_out(req_valid), .req_out(req), .ans_ready_out(ans_ready));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_st(input tsr_pkg::tsr_tag_e exp);
		cmp_count++;
		if (state !== exp) begin
			miscompares++;
			$display("MISMATCH state expected %0d seen %0d", exp, state);
		end
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Silence is judged over the whole window, which outlasts any stalled answer.
	task automatic cmd(input logic [7:0] b[$], input bit bad, input int exp_n, input tsr_pkg::tsr_tag_e exp_st);
		tsr_pkg::tsr_ans_s f[$];
		int                n;
		int                marks;
		u_tsr_reader_model.rx.delete();
		u_tsr_reader_model.send(b, bad);
		for (int i = 0; i < 60; i++) begin
			@(posedge clock_in);
			if (u_tsr_reader_model.rx.size() > 0 && u_tsr_reader_model.rx[$].last) begin
				break;
			end
		end
		f = u_tsr_reader_model.rx;
		n = f.size();
		pl.delete();
		for (int i = 0; i < n - 2; i++) begin
			pl.push_back(f[i].data);
		end
		// Stray frame marks in the middle of an answer would split it at the receiver.
		marks = 0;
		foreach (f[i]) begin
			marks += f[i].first + f[i].last;
		end
		if (exp_n >= 0) begin
			chk("answer length", exp_n, n);
		end
		if (n > 2) begin
			chk("answer check", u_tsr_reader_model.chk(pl), {f[n-1].data, f[n-2].data});
			chk("frame marks", 2'b11, {f[0].first, f[n-1].last});
			chk("frame mark count", 32'h2, marks);
		end
		chk_st(exp_st);
		if (exp_n > 0 && n == 0) begin
			print_verdict();
		end
	endtask

	initial begin
		logic [7:0] hi;
		logic [7:0] ad;
		int         hits;
		bit         polled;
		repeat (3) @(posedge clock_in);
		arst_n_in <= 1'b1;
		for (int i = 0; i < 17; i++) begin
			@(posedge clock_in);
			load_en <= 1'b1;
			load_addr <= 5'(i);
			load_data <= rs;
			mem[i] = rs;
		end
		@(posedge clock_in);
		load_en <= 1'b0;
		chk_st(RDY);
		cmd('{8'h08, 8'h00}, 1'b0, 0, RDY);
		cmd('{8'h0E, 8'h00}, 1'b0, 0, RDY);
		cmd('{8'h16}, 1'b0, 0, RDY);
		cmd('{8'h06, 8'h04}, 1'b0, 0, RDY);
		cmd('{8'h0C}, 1'b0, 0, RDY);
		cmd('{8'h0F}, 1'b0, 0, RDY);
		cmd('{8'h06, 8'h00}, 1'b1, 0, RDY);
		cmd('{8'h06, 8'h00}, 1'b0, 3, INV);
		lbl = pl[0];
		hi = lbl;
		slow = 1'b1;
		cmd('{8'h06, 8'h04}, 1'b0, -1, INV);
		polled = (pl.size() == 1);
		if (polled) begin
			chk("poll label", {hi[7:4], 4'h0}, pl[0]);
			lbl = pl[0];
		end
		hits = 0;
		for (int s = 1; s < 16; s++) begin
			cmd('{{4'(s), 4'h6}}, 1'b0, -1, INV);
			if (pl.size() == 1) begin
				hits++;
				chk("slot label", {hi[7:4], 4'(s)}, pl[0]);
				lbl = pl[0];
			end
		end
		chk("slot answers", polled ? 0 : 1, hits);
		cmd('{8'h08, 8'h00}, 1'b0, 0, INV);
		cmd('{8'h0E, ~lbl}, 1'b0, 0, INV);
		cmd('{8'h0E, lbl}, 1'b1, 0, INV);
		cmd('{8'h0E, lbl}, 1'b0, 3, SEL);
		chk("select label", lbl, pl[0]);
		for (int a = 0; a < 18; a++) begin
			ad = (a == 16) ? 8'hFF : ((a == 17) ? (8'h10 + {1'b0, rs[6:0]}) : 8'(a));
			cmd('{8'h08, ad}, 1'b0, (a < 17) ? 6 : 0, SEL);
			if (a < 17) begin
				chk("block data", mem[a], {pl[3], pl[2], pl[1], pl[0]});
			end
		end
		cmd('{{(lbl[3:0] == 4'h0) ? 4'h1 : lbl[3:0], 4'h6}}, 1'b0, 0, SEL);
		cmd('{8'h08, 8'h00}, 1'b1, 0, SEL);
		cmd('{8'h0C}, 1'b0, 0, INV);
		cmd('{8'h0E, lbl}, 1'b0, 3, SEL);
		cmd('{8'h0E, lbl ^ 8'h01}, 1'b0, 0, DES);
		cmd('{8'h0F}, 1'b0, 0, DES);
		cmd('{8'h0E, lbl}, 1'b0, 3, SEL);
		cmd('{8'h0F}, 1'b0, 0, DEA);
		cmd('{8'h06, 8'h00}, 1'b0, 0, DEA);
		cmd('{8'h0E, lbl}, 1'b0, 0, DEA);
		cmd('{8'h08, 8'h00}, 1'b0, 0, DEA);
		arst_n_in <= 1'b0;
		@(posedge clock_in);
		chk_st(RDY);
		arst_n_in <= 1'b1;
		print_verdict();
	end
endmodule

`default_nettype wire
